// [eis_defines.svh]
/*
  register indices, field positions and reset values of the external
  interrupt sensitivity block.
  assumes the includer maps index n to byte address 4*n on the bus.
*/
// Overview of operation
// - four external sources, each with an independent trigger setting
// - sense fields: src3 bits 7:6, src2 5:4, src1 3:2, src0 1:0
// - codes: 00 falling plus low, 01 rising, 10 falling, 11 both edges
// - sense writes accepted only at core level 3, else value kept
// - writing a new field value clears that source's pending request
// - sense control register is read/write and resets to 00h
// - top polarity bit 1: 0 falling edge, 1 rising edge
// - top polarity writable only while top enable is 0
// - top enable bit 0 gates the dedicated pin, freely writable
// - clearing top enable may raise a spurious top request
// - both core level bits at 1 mean level 3, interrupts disabled
// - servicing the top interrupt sets both core level bits
`ifndef EIS_DEFINES_SVH
`define EIS_DEFINES_SVH

// ==========================================================
// register indices (byte address = 4 * index)
`define EIS_IDX_SENSE    10'h029
`define EIS_IDX_TOP      10'h02A
`define EIS_IDX_STATUS   10'h030
`define EIS_IDX_CLEAR    10'h031
`define EIS_IDX_ENABLE   10'h032

// ==========================================================
// field positions and reset values
`define EIS_FIELD_W      2
`define EIS_TOP_EN_BIT   0
`define EIS_TOP_POL_BIT  1
`define EIS_SENSE_RST    8'h00
`define EIS_TOP_RST      8'h00
`define EIS_IRQ_RST      5'h00
`define EIS_LEVEL3       2'h3

`endif

// [eis_pkg.sv]
/*
  types of the external interrupt sensitivity block.
  assumes eis_defines.svh is on the include path.
*/
`default_nettype none

package eis_pkg;

  // ==========================================================
  // trigger selection codes
  typedef enum logic [1:0]
  {
    EIS_FALL_LOW = 2'h0,
    EIS_RISE     = 2'h1,
    EIS_FALL     = 2'h2,
    EIS_BOTH     = 2'h3
  } eis_trig_t;

  // ==========================================================
  // apb carriers
  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } eis_apb_req_t;

  typedef struct packed
  {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } eis_apb_rsp_t;

endpackage

`default_nettype wire

// [eis_src_det.sv]
/*
  one source: two-flop synchroniser, previous-sample edge detect and
  trigger selection.
  assumes the pin may be fully asynchronous to pclk.
*/
`default_nettype none

module eis_src_det
  import eis_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              pin,
  input  wire eis_pkg::eis_trig_t mode,
  output logic                   hit,
  output logic                   level
);

  import eis_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic rise;
  logic fall;

  // ==========================================================
  // synchroniser and previous sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r  <= 1'b1;
    end
    else
    begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise  = sync2_r & ~prev_r;
  assign fall  = ~sync2_r & prev_r;
  assign level = sync2_r;

  // ==========================================================
  // trigger selection
  always_comb
  begin
    case (mode)
      EIS_FALL_LOW: hit = fall | ~sync2_r;
      EIS_RISE:     hit = rise;
      EIS_FALL:     hit = fall;
      EIS_BOTH:     hit = rise | fall;
      default:      hit = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// [eis_top.sv]
/*
  external interrupt sensitivity block: sense control, top-level
  interrupt control, sticky pending flags and an apb register slave.
  assumes pins arrive asynchronously and the core drives its current
  interrupt level as two plain inputs.
*/
`include "eis_defines.svh"
`default_nettype none

module eis_top
  import eis_pkg::*;
#(
  parameter int N_SRC = 4
)
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire eis_pkg::eis_apb_req_t apb_req,
  output eis_pkg::eis_apb_rsp_t     apb_rsp,
  input  wire logic [N_SRC-1:0]     ext_irq_src,
  input  wire logic                 top_level_irq,
  input  wire logic                 irq_level_hi,
  input  wire logic                 irq_level_lo,
  input  wire logic                 top_irq_ack,
  output logic [N_SRC:0]            irq_pending,
  output logic                      core_level_set,
  output logic                      irq
);

  import eis_pkg::*;

  localparam int NB = N_SRC + 1;
  localparam logic [7:0] TOP_RST = `EIS_TOP_RST;

  if ((N_SRC < 1) || (N_SRC > 4))
  begin : g_chk
    $error("eis_top: N_SRC must lie between 1 and 4");
  end

  // ==========================================================
  // declarations
  logic [7:0]    sense_r;
  logic          top_en_r;
  logic          top_pol_r;
  logic [NB-1:0] status_r;
  logic [NB-1:0] status_nxt;
  logic [NB-1:0] enable_r;
  logic [31:0]   prdata_r;
  logic          slverr_r;
  logic          core_level_set_r;
  logic [NB-1:0] hits;
  logic [NB-1:0] levels;
  logic [NB-1:0] chg_mask;
  logic [NB-1:0] clr_mask;
  logic [NB-1:0] chg_nohit;
  logic [9:0]    idx;
  logic          aligned;
  logic          setup;
  logic          wr_acc;
  logic          level3;
  logic          sel_sense;
  logic          sel_top;
  logic          sel_status;
  logic          sel_clear;
  logic          sel_enable;
  logic          sense_wr;
  logic          top_wr;
  logic          clear_wr;
  logic          top_pin_gated;
  eis_trig_t     top_mode;

  // ==========================================================
  // bus decode
  assign idx        = apb_req.paddr[11:2];
  assign aligned    = (apb_req.paddr[1:0] == 2'h0);
  assign setup      = apb_req.psel & ~apb_req.penable;
  assign wr_acc     = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign sel_sense  = aligned & (idx == `EIS_IDX_SENSE);
  assign sel_top    = aligned & (idx == `EIS_IDX_TOP);
  assign sel_status = aligned & (idx == `EIS_IDX_STATUS);
  assign sel_clear  = aligned & (idx == `EIS_IDX_CLEAR);
  assign sel_enable = aligned & (idx == `EIS_IDX_ENABLE);

  // level 3 is the only level at which sensitivity may move
  assign level3   = ({irq_level_hi, irq_level_lo} == `EIS_LEVEL3);
  assign sense_wr = wr_acc & sel_sense & level3;
  assign top_wr   = wr_acc & sel_top;
  assign clear_wr = wr_acc & sel_clear;

  // ==========================================================
  // sense control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sense_r <= `EIS_SENSE_RST;
    end
    else if (sense_wr)
    begin
      sense_r <= apb_req.pwdata[7:0];
    end
  end

  // ==========================================================
  // top-level interrupt control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      top_en_r  <= TOP_RST[`EIS_TOP_EN_BIT];
      top_pol_r <= TOP_RST[`EIS_TOP_POL_BIT];
    end
    else if (top_wr)
    begin
      top_en_r <= apb_req.pwdata[`EIS_TOP_EN_BIT];
      if (!top_en_r)
      begin
        top_pol_r <= apb_req.pwdata[`EIS_TOP_POL_BIT];
      end
    end
  end

  // ==========================================================
  // source detectors
  for (genvar i = 0; i < N_SRC; i++)
  begin : g_src
    eis_src_det u_det
    (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (ext_irq_src[i]),
      .mode    (eis_trig_t'(sense_r[2*i +: `EIS_FIELD_W])),
      .hit     (hits[i]),
      .level   (levels[i])
    );

    // a differing field value drops what was pending
    assign chg_mask[i] = sense_wr &
      (apb_req.pwdata[2*i +: `EIS_FIELD_W] !=
       sense_r[2*i +: `EIS_FIELD_W]);
  end

  assign chg_mask[N_SRC] = 1'b0;
  assign chg_nohit       = chg_mask & ~hits;

  // disabled pin is held high, the synchroniser's reset level, so no
  // false edge follows reset; a drop of enable while the pin is low
  // looks like a rising edge, and software must tolerate that request
  assign top_pin_gated = top_level_irq | ~top_en_r;
  assign top_mode      = top_pol_r ? EIS_RISE : EIS_FALL;

  eis_src_det u_top_det
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (top_pin_gated),
    .mode    (top_mode),
    .hit     (hits[N_SRC]),
    .level   (levels[N_SRC])
  );

  // ==========================================================
  // sticky pending flags: a new event beats any clear
  assign clr_mask   = (clear_wr ? apb_req.pwdata[NB-1:0] : '0) | chg_mask;
  assign status_nxt = (status_r & ~clr_mask) | hits;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= NB'(`EIS_IRQ_RST);
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_r <= NB'(`EIS_IRQ_RST);
    end
    else if (wr_acc && sel_enable)
    begin
      enable_r <= apb_req.pwdata[NB-1:0];
    end
  end

  assign irq_pending = status_r;
  assign irq         = |(status_r & enable_r);

  // ==========================================================
  // level raise on top-level service
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_level_set_r <= 1'b0;
    end
    else
    begin
      core_level_set_r <= top_irq_ack;
    end
  end

  assign core_level_set = core_level_set_r;

  // ==========================================================
  // read data, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
      if (sel_sense)
      begin
        prdata_r[7:0] <= sense_r;
      end
      else if (sel_top)
      begin
        prdata_r[`EIS_TOP_POL_BIT] <= top_pol_r;
        prdata_r[`EIS_TOP_EN_BIT]  <= top_en_r;
      end
      else if (sel_status)
      begin
        prdata_r[NB-1:0] <= status_r;
      end
      else if (sel_enable)
      begin
        prdata_r[NB-1:0] <= enable_r;
      end
      else if (!sel_clear)
      begin
        slverr_r <= 1'b1;
      end
    end
  end

  // single-cycle access phase; no wait states are ever needed
  assign apb_rsp = '{prdata: prdata_r, pready: 1'b1, pslverr: slverr_r};

  // ==========================================================
  // assertions
  property p_sense_locked;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && sel_sense && !level3) |=> $stable(sense_r);
  endproperty
  a_sense_locked: assert property (p_sense_locked)
    else $error("sense field changed outside level 3");

  property p_sense_write;
    @(posedge pclk) disable iff (!presetn)
    sense_wr |=> (sense_r == $past(apb_req.pwdata[7:0]));
  endproperty
  a_sense_write: assert property (p_sense_write)
    else $error("accepted sense write not stored");

  property p_change_clears;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((status_r & $past(chg_nohit)) == '0);
  endproperty
  a_change_clears: assert property (p_change_clears)
    else $error("sense change left request pending");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (hits != '0) |=> ((status_r & $past(hits)) == $past(hits));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against a clear");

  property p_pol_locked;
    @(posedge pclk) disable iff (!presetn)
    (top_wr && top_en_r) |=> $stable(top_pol_r);
  endproperty
  a_pol_locked: assert property (p_pol_locked)
    else $error("top polarity changed while enabled");

  property p_top_gate;
    @(posedge pclk) disable iff (!presetn)
    (!top_en_r) [*4] |-> !hits[N_SRC];
  endproperty
  a_top_gate: assert property (p_top_gate)
    else $error("top request while disabled");

  property p_low_holds;
    @(posedge pclk) disable iff (!presetn)
    (sense_r[1:0] == 2'h0 && !levels[0]) |=> status_r[0];
  endproperty
  a_low_holds: assert property (p_low_holds)
    else $error("low level did not hold request");

  property p_rise_only;
    @(posedge pclk) disable iff (!presetn)
    (sense_r[1:0] == 2'h1 && hits[0]) |-> (levels[0] && !$past(levels[0]));
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("rising mode fired without rising edge");

  property p_level_set;
    @(posedge pclk) disable iff (!presetn)
    top_irq_ack |=> core_level_set ##1 (core_level_set == $past(top_irq_ack));
  endproperty
  a_level_set: assert property (p_level_set)
    else $error("core level not raised on top service");

  property p_irq_out;
    @(posedge pclk) disable iff (!presetn)
    ((status_r & enable_r) != '0) |->
      irq ##1 ((status_r & enable_r) != '0 || !irq);
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("interrupt output disagrees with flags");

  property p_top_pol;
    @(posedge pclk) disable iff (!presetn)
    hits[N_SRC] |-> (levels[N_SRC] == top_pol_r);
  endproperty
  a_top_pol: assert property (p_top_pol)
    else $error("top request on the wrong edge");

  property p_pol_write;
    @(posedge pclk) disable iff (!presetn)
    (top_wr && !top_en_r) |=>
      (top_pol_r == $past(apb_req.pwdata[`EIS_TOP_POL_BIT]));
  endproperty
  a_pol_write: assert property (p_pol_write)
    else $error("top polarity write lost while disabled");

  c_src0_rise: cover property
    (@(posedge pclk) disable iff (!presetn) sense_r[1:0] == 2'h1 && hits[0]);

  c_locked_write: cover property
    (@(posedge pclk) disable iff (!presetn) wr_acc && sel_sense && !level3);
  c_change_clear: cover property
    (@(posedge pclk) disable iff (!presetn) status_r[0] && chg_mask[0]);
  c_top_hit: cover property
    (@(posedge pclk) disable iff (!presetn) hits[N_SRC] && top_pol_r);

endmodule

`default_nettype wire

// [eis_far_model.sv]
/*
  far side of the sensitivity block: external pins and the core's
  interrupt level logic, driven by tasks of the testbench.
  assumes pclk is the block's clock and pins have pull-ups.
*/
`default_nettype none

module eis_far_model
(
  input  wire logic  pclk,
  input  wire logic  core_level_set,
  output logic [3:0] ext_irq_src,
  output logic       top_level_irq,
  output logic       irq_level_hi,
  output logic       irq_level_lo,
  output logic       top_irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // idle state: pins pulled high, level 0
  initial
  begin
    ext_irq_src   = 4'hF;
    top_level_irq = 1'b1;
    irq_level_hi  = 1'b0;
    irq_level_lo  = 1'b0;
    top_irq_ack   = 1'b0;
  end

  // ==========================================================
  // core side: top service forces level 3
  always @(posedge pclk)
    if (core_level_set)
    begin
      irq_level_hi <= 1'b1;
      irq_level_lo <= 1'b1;
    end

  task automatic set_level(input logic [1:0] l);
    @(posedge pclk);
    {irq_level_hi, irq_level_lo} <= l;
  endtask

  task automatic set_pins(input logic [3:0] s, input logic t);
    @(posedge pclk);
    ext_irq_src   <= s;
    top_level_irq <= t;
  endtask

  task automatic ack;
    @(posedge pclk);
    top_irq_ack <= 1'b1;
    @(posedge pclk);
    top_irq_ack <= 1'b0;
  endtask

endmodule

`default_nettype wire

// [external_interrupt_sensitivity_tb_top.sv]
/*
  register-level testbench of the sensitivity block over apb.
  assumes eis_far_model drives pins and level; one clock domain.
*/
`default_nettype none

module external_interrupt_sensitivity_tb_top
  import eis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  localparam logic [11:0] A_SENSE = 12'h0A4;
  localparam logic [11:0] A_TOP   = 12'h0A8;
  localparam logic [11:0] A_STAT  = 12'h0C0;
  localparam logic [11:0] A_CLR   = 12'h0C4;
  localparam logic [11:0] A_EN    = 12'h0C8;
  localparam logic [11:0] A_BAD   = 12'h100;

  logic         pclk;
  logic         presetn;
  eis_apb_req_t req;
  eis_apb_rsp_t rsp;
  logic [3:0]   src;
  logic         top_pin;
  logic         lhi;
  logic         llo;
  logic         ack;
  logic [4:0]   pend;
  logic         lvl_set;
  logic         irq;
  logic [31:0]  rd;
  logic         err;
  int           errors;
  int           cmp_count;

  always #5 pclk = ~pclk;

  eis_top u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .ext_irq_src(src), .top_level_irq(top_pin),
    .irq_level_hi(lhi), .irq_level_lo(llo), .top_irq_ack(ack),
    .irq_pending(pend), .core_level_set(lvl_set), .irq(irq));

  eis_far_model u_far (.pclk(pclk), .core_level_set(lvl_set),
    .ext_irq_src(src), .top_level_irq(top_pin), .irq_level_hi(lhi),
    .irq_level_lo(llo), .top_irq_ack(ack));

  // ==========================================================
  // tasks
  task automatic test_done;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask

  task automatic chk_bit(input string w, input logic e, input logic g);
    chk(w, {31'h0, e}, {31'h0, g});
  endtask

  // one transfer; waits for pready, takes data at that edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rdchk(input string w, input logic [11:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask

  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask

  // ==========================================================
  // watchdog
  initial
  begin
    repeat (5000) @(posedge pclk);
    errors++;
    test_done;
  end

  // ==========================================================
  // tests
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("sense reset", A_SENSE, 32'h0);
    rdchk("top reset", A_TOP, 32'h0);
    rdchk("status reset", A_STAT, 32'h0);
    apb(1'b0, A_BAD, 32'h0);
    chk_bit("unmapped err", 1'b1, err);
    u_far.set_level(2'h2);
    apb(1'b1, A_SENSE, 32'hE4);
    rdchk("sense lvl2", A_SENSE, 32'h0);
    u_far.set_level(2'h3);
    apb(1'b1, A_SENSE, 32'hE4);
    rdchk("sense lvl3", A_SENSE, 32'hE4);
    apb(1'b1, A_EN, 32'h1F);
    rdchk("enable", A_EN, 32'h1F);
    // four modes at once: 00, 01, 10, 11 on src0..src3
    u_far.set_pins(4'h0, 1'b1);
    settle;
    rdchk("falls", A_STAT, 32'h0D);
    chk("pending pins", 32'h0D, {27'h0, pend});
    chk_bit("irq on", 1'b1, irq);
    apb(1'b1, A_CLR, 32'h0F);
    rdchk("low holds", A_STAT, 32'h01);
    u_far.set_pins(4'hF, 1'b1);
    settle;
    rdchk("rises", A_STAT, 32'h0B);
    apb(1'b1, A_SENSE, 32'h25);
    rdchk("change clears", A_STAT, 32'h02);
    apb(1'b1, A_EN, 32'h0);
    @(posedge pclk);
    chk_bit("irq masked", 1'b0, irq);
    apb(1'b1, A_EN, 32'h1F);
    @(posedge pclk);
    chk_bit("irq unmasked", 1'b1, irq);
    apb(1'b1, A_STAT, 32'h1F);
    rdchk("status ro", A_STAT, 32'h02);
    apb(1'b1, A_CLR, 32'h1F);
    rdchk("cleared", A_STAT, 32'h0);
    rdchk("clear reads 0", A_CLR, 32'h0);
    chk_bit("irq off", 1'b0, irq);
    apb(1'b1, A_TOP, 32'h3);
    rdchk("top set", A_TOP, 32'h3);
    apb(1'b1, A_TOP, 32'h1);
    rdchk("pol locked", A_TOP, 32'h3);
    u_far.set_pins(4'hE, 1'b0);
    settle;
    rdchk("top fall", A_STAT, 32'h0);
    u_far.set_pins(4'hF, 1'b1);
    settle;
    rdchk("top rise", A_STAT, 32'h11);
    apb(1'b1, A_CLR, 32'h11);
    apb(1'b1, A_TOP, 32'h0);
    rdchk("pol kept", A_TOP, 32'h2);
    apb(1'b1, A_TOP, 32'h0);
    rdchk("top off", A_TOP, 32'h0);
    // a spurious top request may follow disabling; drop it
    apb(1'b1, A_CLR, 32'h1F);
    u_far.set_pins(4'hF, 1'b0);
    settle;
    u_far.set_pins(4'hF, 1'b1);
    settle;
    rdchk("top gated", A_STAT, 32'h0);
    u_far.set_level(2'h0);
    u_far.ack;
    @(posedge pclk);
    chk_bit("level set", 1'b1, lvl_set);
    repeat (2) @(posedge pclk);
    chk_bit("level 3", 1'b1, lhi & llo);
    test_done;
  end

endmodule

`default_nettype wire
